/* hdl/stse_defines.vh */
`ifndef STSE_DEFINES_VH
`define STSE_DEFINES_VH

// ==========================================================================
// operation select codes from the instruction decoder
`define STSE_OP_W                       3
`define STSE_OP_SKIP_IF_NONZERO_OP_BIT  3'h0
`define STSE_OP_SKIP_IF_NONZERO_OP_BYTE 3'h1
`define STSE_OP_SUBTRACT_OP             3'h2
`define STSE_OP_SUBTRACT_TO_MEMORY_OP   3'h3
`define STSE_OP_SUBTRACT_IMM_OP         3'h4

// ==========================================================================
// datapath geometry
`define STSE_DATA_W                     8
`define STSE_BIT_SEL_W                  3

// ==========================================================================
// reset values and sequencer state codes
`define STSE_ZERO_BYTE                  8'h00
`define STSE_ST_W                       2
`define STSE_ST_RUN                     2'h1
`define STSE_ST_DUMMY                   2'h2

`endif

/* hdl/stse_exec.v */
`timescale 1ns/100ps
`include "stse_defines.vh"
`default_nettype none

// What this block does
// - A bit-test skip skips the next instruction when the chosen bit of the memory byte is one, and leaves the byte alone.
// - A byte-test skip skips the next instruction when the memory byte holds any nonzero value.
// - A taken skip adds one dummy instruction cycle, so the skip instruction takes two cycles.
// - When the tested value is zero no skip happens and execution goes on with the next instruction.
// - The memory subtract puts accumulator minus memory byte into the accumulator and leaves memory unchanged.
// - The write-back subtract stores accumulator minus memory byte into that memory location, not the accumulator.
// - The immediate subtract puts accumulator minus the instruction constant into the accumulator.
// - Every subtract clears carry on a borrow and sets it when the difference is zero or positive.
// - Every subtract updates overflow, zero, half borrow, carry and both compare flags, and the skips change no flag.
module stse_exec #(
	parameter DATA_W = `STSE_DATA_W
) (
	input  wire              clk,
	input  wire              resetn,
	input  wire              op_valid,
	input  wire [2:0]        op_code,
	input  wire [2:0]        bit_sel,
	input  wire [DATA_W-1:0] mem_rdata,
	input  wire [DATA_W-1:0] acc_in,
	input  wire [DATA_W-1:0] imm_data,
	output reg               op_ready_q,
	output reg               skip_q,
	output reg               dummy_cycle_q,
	output reg               acc_we_q,
	output reg  [DATA_W-1:0] acc_wdata_q,
	output reg               mem_we_q,
	output reg  [DATA_W-1:0] mem_wdata_q,
	output reg               flags_we_q,
	output reg               overflow_flag_q,
	output reg               zero_flag_q,
	output reg               half_borrow_flag_q,
	output reg               carry_flag_q,
	output reg               signed_compare_flag_q,
	output reg               chained_zero_flag_q
);

	// ======================================================================
	// reset release
	reg                      rst_meta_q;
	reg                      rst_n_q;

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ======================================================================
	// subtract with borrow, result {borrow, half_borrow, overflow, diff}
	function [DATA_W+2:0] stse_sub;
		input [DATA_W-1:0] a;
		input [DATA_W-1:0] b;
		reg   [DATA_W:0]   wide;
		reg                hb;
		reg                ov;
		begin
			wide = {1'b0, a} - {1'b0, b};
			hb   = (a[3:0] < b[3:0]);
			ov   = (a[DATA_W-1] ^ b[DATA_W-1]) & (a[DATA_W-1] ^ wide[DATA_W-1]);
			stse_sub = {wide[DATA_W], hb, ov, wide[DATA_W-1:0]};
		end
	endfunction

	// ======================================================================
	// decode
	reg  [`STSE_ST_W-1:0]    state_q;
	reg  [`STSE_ST_W-1:0]    state_d;
	wire                     take = op_valid & op_ready_q & (state_q == `STSE_ST_RUN);
	wire                     is_bit  = (op_code == `STSE_OP_SKIP_IF_NONZERO_OP_BIT);
	wire                     is_byte = (op_code == `STSE_OP_SKIP_IF_NONZERO_OP_BYTE);
	wire                     is_sub  = (op_code == `STSE_OP_SUBTRACT_OP);
	wire                     is_subtract_to_memory_op = (op_code == `STSE_OP_SUBTRACT_TO_MEMORY_OP);
	wire                     is_subi = (op_code == `STSE_OP_SUBTRACT_IMM_OP);
	wire                     any_sub = is_sub | is_subtract_to_memory_op | is_subi;

	// only the selected bit is looked at; the byte is never written back
	wire                     bit_hit  = is_bit & mem_rdata[bit_sel];
	wire                     byte_hit = is_byte & (mem_rdata != `STSE_ZERO_BYTE);
	// a zero value falls through to the next instruction
	wire                     skip_now = take & (bit_hit | byte_hit);

	wire [DATA_W-1:0]        sub_rhs = is_subi ? imm_data : mem_rdata;
	wire [DATA_W+2:0]        sub_res = stse_sub(acc_in, sub_rhs);
	wire [DATA_W-1:0]        diff    = sub_res[DATA_W-1:0];
	wire                     diff_z  = (diff == `STSE_ZERO_BYTE);

	// ======================================================================
	// skip sequencing
	always @*
	begin
		state_d = state_q;
		case (state_q)
			`STSE_ST_RUN:
			begin
				if (skip_now)
					state_d = `STSE_ST_DUMMY;
			end
			`STSE_ST_DUMMY:
			begin
				state_d = `STSE_ST_RUN;
			end
			default:
			begin
				state_d = `STSE_ST_RUN;
			end
		endcase
	end

	// ======================================================================
	// sequencer state
	always @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			state_q    <= `STSE_ST_RUN;
			op_ready_q <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			// decoder is held off during the dummy cycle
			op_ready_q <= (state_d == `STSE_ST_RUN);
		end
	end

	// ======================================================================
	// skip pulses
	always @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			skip_q        <= 1'b0;
			dummy_cycle_q <= 1'b0;
		end
		else
		begin
			// both last one cycle; the fetch side drops the next instruction
			skip_q        <= skip_now;
			dummy_cycle_q <= skip_now;
		end
	end

	// ======================================================================
	// write enables
	always @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			acc_we_q   <= 1'b0;
			mem_we_q   <= 1'b0;
			flags_we_q <= 1'b0;
		end
		else
		begin
			acc_we_q   <= take & (is_sub | is_subi);
			mem_we_q   <= take & is_subtract_to_memory_op;
			// flag write only on subtracts, skips leave them as they are
			flags_we_q <= take & any_sub;
		end
	end

	// ======================================================================
	// result data
	always @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			acc_wdata_q <= `STSE_ZERO_BYTE;
			mem_wdata_q <= `STSE_ZERO_BYTE;
		end
		else
		begin
			// both copies follow every subtract; only the enables differ
			if (take & any_sub)
			begin
				acc_wdata_q <= diff;
				mem_wdata_q <= diff;
			end
		end
	end

	// ======================================================================
	// status flags
	always @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			overflow_flag_q       <= 1'b0;
			zero_flag_q           <= 1'b0;
			half_borrow_flag_q    <= 1'b0;
			carry_flag_q          <= 1'b0;
			signed_compare_flag_q <= 1'b0;
			chained_zero_flag_q   <= 1'b0;
		end
		else
		begin
			if (take & any_sub)
			begin
				carry_flag_q          <= ~sub_res[DATA_W+2];
				half_borrow_flag_q    <= sub_res[DATA_W+1];
				overflow_flag_q       <= sub_res[DATA_W];
				zero_flag_q           <= diff_z;
				// signed less-than corrects the sign bit for overflow
				signed_compare_flag_q <= sub_res[DATA_W] ^ diff[DATA_W-1];
				// no incoming borrow here, so the chained zero equals zero
				chained_zero_flag_q   <= diff_z;
			end
		end
	end

endmodule // stse_exec

`default_nettype wire

/* sim/skip_test_and_subtract_exec_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// rows: op byte (bit index in high nibble), acc, operand, result,
// {half borrow,signed cmp,chained zero,dummy,skip,carry,zero,ovf}
module skip_test_and_subtract_exec_tb_top;
	logic clk = 1'b0, resetn = 1'b0, op_valid = 1'b0;
	logic [2:0] op_code = 3'h0, bit_sel = 3'h0;
	logic [7:0] mem_rdata = 8'h00, acc_in = 8'h00, imm_data = 8'h00;
	wire op_ready_q, skip_q, dummy_cycle_q, acc_we_q, mem_we_q, flags_we_q, overflow_flag_q;
	wire zero_flag_q, half_borrow_flag_q, carry_flag_q, signed_compare_flag_q, chained_zero_flag_q;
	wire [7:0] acc_wdata_q, mem_wdata_q;
	int n_errors = 0, num_checks = 0;
	logic [39:0] rows [10] = '{40'h02_05_07_FE_C0, 40'h02_07_07_00_26, 40'h03_10_01_0F_84,
		40'h04_00_01_FF_C0, 40'h04_80_01_7F_C5, 40'h01_00_03_7F_DD, 40'h01_00_00_7F_C5,
		40'h70_00_80_7F_DD, 40'h70_00_7F_7F_C5, 40'h04_7F_FF_80_01};
	stse_exec dut (.clk(clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
		.bit_sel(bit_sel), .mem_rdata(mem_rdata), .acc_in(acc_in), .imm_data(imm_data),
		.op_ready_q(op_ready_q), .skip_q(skip_q), .dummy_cycle_q(dummy_cycle_q),
		.acc_we_q(acc_we_q), .acc_wdata_q(acc_wdata_q), .mem_we_q(mem_we_q),
		.mem_wdata_q(mem_wdata_q), .flags_we_q(flags_we_q), .overflow_flag_q(overflow_flag_q),
		.zero_flag_q(zero_flag_q), .half_borrow_flag_q(half_borrow_flag_q),
		.carry_flag_q(carry_flag_q), .signed_compare_flag_q(signed_compare_flag_q),
		.chained_zero_flag_q(chained_zero_flag_q));
	always #5 clk = ~clk;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// op_valid stays up between rows so takes run back to back, and waits out the dummy cycle
	task automatic take(input logic [39:0] r);
		op_valid = 1'b1;
		op_code = r[34:32];
		bit_sel = r[38:36];
		acc_in = r[31:24];
		mem_rdata = r[23:16];
		imm_data = r[23:16];
		for (int w = 0; w < 8 && op_ready_q !== 1'b1; w++)
			@(posedge clk) #1;
		@(posedge clk) #1;
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#5000;
		n_errors++;
		close_out;
	end
	initial
	begin
		repeat (10) @(posedge clk);
		#1 resetn = 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			take(rows[i]);
			chk(op_code == 3'h3 ? mem_wdata_q : acc_wdata_q, rows[i][15:8]);
			chk({half_borrow_flag_q, signed_compare_flag_q, chained_zero_flag_q, dummy_cycle_q,
				skip_q, carry_flag_q, zero_flag_q, overflow_flag_q}, rows[i][7:0]);
			chk({6'h0, acc_we_q, mem_we_q}, {6'h0, op_code[2] | (op_code == 3'h2), op_code == 3'h3});
		end
		// reset mid-run with a request still offered: it must wait for ready again
		resetn = 1'b0;
		#1;
		chk({acc_wdata_q[6:0], carry_flag_q}, 8'h00);
		@(posedge clk) #1 resetn = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk({7'h0, acc_we_q}, 8'h00);
		take(rows[4]);
		chk({acc_wdata_q[6:0], overflow_flag_q}, 8'hFF);
		close_out;
	end
endmodule // skip_test_and_subtract_exec_tb_top
bind stse_exec stse_exec_monitor #(.DATA_W(DATA_W)) u_mon (.clk(clk), .resetn(resetn),
	.op_valid(op_valid), .op_ready_q(op_ready_q), .skip_q(skip_q),
	.dummy_cycle_q(dummy_cycle_q), .acc_we_q(acc_we_q), .mem_we_q(mem_we_q),
	.flags_we_q(flags_we_q), .carry_flag_q(carry_flag_q), .zero_flag_q(zero_flag_q),
	.op_code(op_code), .bit_sel(bit_sel), .mem_rdata(mem_rdata), .acc_in(acc_in),
	.imm_data(imm_data), .acc_wdata_q(acc_wdata_q), .mem_wdata_q(mem_wdata_q));
`default_nettype wire

/* sim/stse_exec_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checks of the execute block
module stse_exec_monitor #(
	parameter DATA_W = 8
) (
	input wire logic              clk, resetn, op_valid, op_ready_q, skip_q, dummy_cycle_q,
	input wire logic              acc_we_q, mem_we_q, flags_we_q, carry_flag_q, zero_flag_q,
	input wire logic [2:0]        op_code, bit_sel,
	input wire logic [DATA_W-1:0] mem_rdata, acc_in, imm_data, acc_wdata_q, mem_wdata_q
);
	wire tk = op_valid & op_ready_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_bit_skip: assert property (tk && op_code == 3'h0 && mem_rdata[bit_sel] |=> skip_q)
		else $error("bit skip not raised");
	a_byte_skip: assert property (tk && op_code == 3'h1 && mem_rdata != 0
		|=> skip_q && dummy_cycle_q && !op_ready_q ##1 op_ready_q && !skip_q) else $error("byte skip wrong");
	a_zero_stay: assert property (tk && op_code == 3'h1 && mem_rdata == 0 |=> !skip_q && op_ready_q)
		else $error("skip on zero byte");
	a_skip_quiet: assert property (tk && op_code < 3'h2 |=> !(acc_we_q | mem_we_q | flags_we_q))
		else $error("skip wrote something");
	a_sub_acc: assert property (tk && op_code == 3'h2 |=> acc_we_q && !mem_we_q
		&& acc_wdata_q == $past(acc_in) - $past(mem_rdata)) else $error("acc subtract wrong");
	a_sub_mem: assert property (tk && op_code == 3'h3 |=> mem_we_q && !acc_we_q
		&& mem_wdata_q == $past(acc_in) - $past(mem_rdata)) else $error("memory subtract wrong");
	a_sub_imm: assert property (tk && op_code == 3'h4 |=> acc_we_q
		&& acc_wdata_q == $past(acc_in) - $past(imm_data)) else $error("immediate subtract wrong");
	a_carry_zero: assert property (tk && op_code == 3'h2 |=> flags_we_q
		&& carry_flag_q == ($past(acc_in) >= $past(mem_rdata))
		&& zero_flag_q == ($past(acc_in) == $past(mem_rdata))) else $error("carry or zero wrong");
	a_flags_held: assert property (!flags_we_q |-> $stable(carry_flag_q) && $stable(zero_flag_q))
		else $error("flags moved without subtract");
endmodule // stse_exec_monitor
`default_nettype wire
